// ---- hw/port0_pin_pkg.sv ----
// port 0 pin control: mode encodings, strap codes and timing counts
// assumes core_clk at 100 MHz and a 50 MHz reference clock in the rmii modes
package port0_pin_pkg;

  // ==========================================================================
  // strap encodings
  localparam logic [2:0] STRAP_MII_MAC      = 3'h0;
  localparam logic [2:0] STRAP_MII_PHY      = 3'h1;
  localparam logic [2:0] STRAP_PHY200_12MA  = 3'h2;
  localparam logic [2:0] STRAP_PHY200_16MA  = 3'h3;
  localparam logic [2:0] STRAP_RMII_OUT_12  = 3'h4;
  localparam logic [2:0] STRAP_RMII_OUT_16  = 3'h5;
  localparam logic [2:0] STRAP_RMII_CLK_IN  = 3'h6;
  localparam logic [2:0] STRAP_RESERVED     = 3'h7;
  localparam logic [2:0] STRAP_RESET_VALUE  = 3'h0;

  // ==========================================================================
  // decoded modes, one-hot
  typedef enum logic [5:0] {
    MODE_MII_MAC    = 6'h01,
    MODE_MII_PHY    = 6'h02,
    MODE_MII_PHY200 = 6'h04,
    MODE_RMII_OUT   = 6'h08,
    MODE_RMII_IN    = 6'h10,
    MODE_RESERVED   = 6'h20
  } mode_type;

  // ==========================================================================
  // timing
  localparam int CORE_CLK_MHZ    = 100;
  localparam int REF_CLK_MHZ     = 50;
  localparam int REF_HALF_CYCLES = CORE_CLK_MHZ / (2 * REF_CLK_MHZ);
  localparam int DIV_WIDTH       = 4;
  // cycles after reset release before the synchronised strap is trusted
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

endpackage : port0_pin_pkg

// ---- hw/sync_cell.sv ----
// two-flop synchroniser for a group of level signals
// assumes the source is quasi-static relative to the destination clock
module sync_cell #(
  parameter int WIDTH = 1
) (
  // destination domain
  input  wire logic             clk,
  input  wire logic             reset,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_type;

  sync_state_type state_q;
  sync_state_type state_d;

  always_comb begin
    state_d        = state_q;
    state_d.first  = asyncIn;
    state_d.second = state_q.first;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.second;

endmodule : sync_cell

// ---- hw/port0_pin_control.sv ----
// port 0 pin control: strap capture, reference clock pin and col/crs pins
// assumes the isolate, clock direction and clock strength bits come from
// core logic on core_clk; linkClk times the col and crs pin drive, the reference clock comes from core_clk

// Functional notes
// - decode three-bit strap into port mode
// - latch strap after reset release, hold it
// - rmii reference clock 50 MHz times data
// - direction bit low input, high output
// - input reference clock normally has pull-down
// - isolate kills input buffer and pull-down; mac mode keeps both on
// - output reference clock: buffer, pull-down off
// - strength bit picks 12 or 16 mA
// - isolate disables reference clock driver
// - phy mode: drive collision unless isolated
// - phy mode: drive carrier unless isolated
// - rmii mode: col and crs unused
module port0_pin_control import port0_pin_pkg::*; (
  // clocks and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       linkClk,
  // strap pins
  input  wire logic [2:0] modeStrapPin,
  // control bits from core logic
  input  wire logic       clkDirOutput,
  input  wire logic       clkStrength16,
  input  wire logic       isolate,
  // events to present in phy modes
  input  wire logic       collisionEvent,
  input  wire logic       carrierEvent,
  // collision pin
  input  wire logic       colIn,
  output logic            colOut,
  output logic            colOutEn_n,
  // carrier sense pin
  input  wire logic       crsIn,
  output logic            crsOut,
  output logic            crsOutEn_n,
  // reference clock pin
  output logic            refClkOut,
  output logic            refClkOutEn_n,
  output logic            refClkInBufEn,
  output logic            refClkPullDownEn,
  output logic            refClkDrive16mA,
  // status to core logic
  output logic [2:0]      portModeStrap,
  output logic            modeValid,
  output logic            collisionSeen,
  output logic            carrierSeen
);

  // ==========================================================================
  // core domain state
  typedef struct packed {
    logic [1:0]           settleCnt;
    logic                 captured;
    logic [2:0]           strap;
    mode_type             mode;
    logic [DIV_WIDTH-1:0] divCnt;
    logic                 refClk;
    logic                 refOutEn_n;
    logic                 inBufEn;
    logic                 pullDownEn;
    logic                 drive16;
    logic                 colEn_n;
    logic                 crsEn_n;
    logic                 colSeen;
    logic                 crsSeen;
  } core_state_type;

  // ==========================================================================
  // link domain state
  typedef struct packed {
    logic colDrive;
    logic crsDrive;
  } link_state_type;

  core_state_type core_q;
  core_state_type core_d;
  link_state_type link_q;
  link_state_type link_d;

  logic [2:0] strapSync;
  logic [1:0] pinSync;
  logic [1:0] eventSync;

  // ==========================================================================
  // crossings
  sync_cell #(.WIDTH(3)) strapSyncCell (
    .clk     (core_clk),
    .reset   (reset),
    .asyncIn (modeStrapPin),
    .syncOut (strapSync)
  );

  sync_cell #(.WIDTH(2)) pinSyncCell (
    .clk     (core_clk),
    .reset   (reset),
    .asyncIn ({colIn, crsIn}),
    .syncOut (pinSync)
  );

  // events reach the pins in the link clock's timing
  sync_cell #(.WIDTH(2)) eventSyncCell (
    .clk     (linkClk),
    .reset   (reset),
    .asyncIn ({collisionEvent, carrierEvent}),
    .syncOut (eventSync)
  );

  // ==========================================================================
  // core logic
  always_comb begin
    logic macMode;
    logic phyMode;
    logic rmiiMode;
    logic clkIsOut;
    macMode  = 1'b0;
    phyMode  = 1'b0;
    rmiiMode = 1'b0;
    clkIsOut = 1'b0;
    core_d   = core_q;

    // strap is taken once, after the synchronisers have filled
    if (!core_q.captured) begin
      if (core_q.settleCnt == STRAP_SETTLE_CYCLES) begin
        core_d.captured = 1'b1;
        core_d.strap    = strapSync;
        unique case (strapSync)
          STRAP_MII_MAC:                      core_d.mode = MODE_MII_MAC;
          STRAP_MII_PHY:                      core_d.mode = MODE_MII_PHY;
          STRAP_PHY200_12MA, STRAP_PHY200_16MA: core_d.mode = MODE_MII_PHY200;
          STRAP_RMII_OUT_12, STRAP_RMII_OUT_16: core_d.mode = MODE_RMII_OUT;
          STRAP_RMII_CLK_IN:                  core_d.mode = MODE_RMII_IN;
          STRAP_RESERVED:                     core_d.mode = MODE_RESERVED;
        endcase
      end else begin
        core_d.settleCnt = core_q.settleCnt + 2'h1;
      end
    end

    macMode  = core_q.captured && (core_q.mode == MODE_MII_MAC);
    phyMode  = core_q.captured &&
               ((core_q.mode == MODE_MII_PHY) || (core_q.mode == MODE_MII_PHY200));
    rmiiMode = core_q.captured &&
               ((core_q.mode == MODE_RMII_OUT) || (core_q.mode == MODE_RMII_IN));
    clkIsOut = rmiiMode && clkDirOutput;

    // 50 MHz reference from the core clock by a counted toggle
    if (core_q.divCnt == DIV_WIDTH'(REF_HALF_CYCLES - 1)) begin
      core_d.divCnt = '0;
      core_d.refClk = ~core_q.refClk;
    end else begin
      core_d.divCnt = core_q.divCnt + DIV_WIDTH'(1);
    end

    core_d.refOutEn_n = ~(clkIsOut && !isolate);
    core_d.drive16    = clkStrength16;
    if (rmiiMode && !clkDirOutput) begin
      core_d.inBufEn    = !isolate;
      core_d.pullDownEn = !isolate;
    end else if (macMode) begin
      core_d.inBufEn    = 1'b1;
      core_d.pullDownEn = 1'b1;
    end else begin
      core_d.inBufEn    = 1'b0;
      core_d.pullDownEn = 1'b0;
    end

    // only the phy modes drive col and crs; rmii leaves both alone
    core_d.colEn_n = ~(phyMode && !isolate);
    core_d.crsEn_n = ~(phyMode && !isolate);
    core_d.colSeen = macMode && pinSync[1];
    core_d.crsSeen = macMode && pinSync[0];
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      core_q            <= '0;
      core_q.strap      <= STRAP_RESET_VALUE;
      core_q.mode       <= MODE_MII_MAC;
      core_q.refOutEn_n <= 1'b1;
      core_q.colEn_n    <= 1'b1;
      core_q.crsEn_n    <= 1'b1;
    end else begin
      core_q <= core_d;
    end
  end

  // ==========================================================================
  // link logic
  always_comb begin
    link_d          = link_q;
    link_d.colDrive = eventSync[1];
    link_d.crsDrive = eventSync[0];
  end

  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // ==========================================================================
  // outputs
  assign colOut           = link_q.colDrive;
  assign crsOut           = link_q.crsDrive;
  assign colOutEn_n       = core_q.colEn_n;
  assign crsOutEn_n       = core_q.crsEn_n;
  assign refClkOut        = core_q.refClk;
  assign refClkOutEn_n    = core_q.refOutEn_n;
  assign refClkInBufEn    = core_q.inBufEn;
  assign refClkPullDownEn = core_q.pullDownEn;
  assign refClkDrive16mA  = core_q.drive16;
  assign portModeStrap    = core_q.strap;
  assign modeValid        = core_q.captured;
  assign collisionSeen    = core_q.colSeen;
  assign carrierSeen      = core_q.crsSeen;

endmodule : port0_pin_control

// ---- bench/port0_pin_control_asserts.sv ----
// checker for port 0 pin control, bound to the top module
// assumes the strap is latched once modeValid is high
module port0_pin_control_asserts (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       reset,
  // mode and controls
  input wire logic       modeValid,
  input wire logic [2:0] portModeStrap,
  input wire logic       clkDirOutput,
  input wire logic       clkStrength16,
  input wire logic       isolate,
  // pins
  input wire logic       colIn,
  input wire logic       crsIn,
  input wire logic       colOutEn_n,
  input wire logic       crsOutEn_n,
  input wire logic       refClkOut,
  input wire logic       refClkOutEn_n,
  input wire logic       refClkInBufEn,
  input wire logic       refClkPullDownEn,
  input wire logic       refClkDrive16mA,
  input wire logic       collisionSeen,
  input wire logic       carrierSeen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rmii;
  logic phy;
  logic mac;
  assign rmii = modeValid && (portModeStrap inside {3'h4, 3'h5, 3'h6});
  assign phy  = modeValid && (portModeStrap inside {3'h1, 3'h2, 3'h3});
  assign mac  = modeValid && (portModeStrap == 3'h0);

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // sequences: col and crs enables are registered on core_clk and follow isolate one core cycle later
  sequence s_iso_held;  (phy && isolate)[*6];  endsequence
  sequence s_live_held; (phy && !isolate)[*6]; endsequence
  sequence s_mac_high;  (mac && colIn && crsIn)[*4]; endsequence

  // ==========================================================================
  property p_strap_held; modeValid |=> modeValid && $stable(portModeStrap); endproperty
  property p_ref_in;
    rmii && !clkDirOutput && !isolate |=> refClkInBufEn && refClkPullDownEn && refClkOutEn_n;
  endproperty
  property p_ref_in_iso;
    rmii && !clkDirOutput && isolate |=> !refClkInBufEn && !refClkPullDownEn;
  endproperty
  property p_ref_out; rmii && clkDirOutput |=> !refClkInBufEn && !refClkPullDownEn; endproperty
  property p_ref_drive;
    rmii && clkDirOutput && !isolate |=>
      !refClkOutEn_n && (refClkDrive16mA == $past(clkStrength16));
  endproperty
  property p_ref_iso; rmii && clkDirOutput && isolate |=> refClkOutEn_n; endproperty
  property p_ref_toggle;
    (rmii && clkDirOutput && !isolate)[*2] |=> refClkOut != $past(refClkOut);
  endproperty
  property p_phy_iso;  s_iso_held |-> colOutEn_n && crsOutEn_n; endproperty
  property p_phy_live; s_live_held |-> !colOutEn_n && !crsOutEn_n; endproperty
  property p_rmii_idle;
    rmii |=> colOutEn_n && crsOutEn_n && !collisionSeen && !carrierSeen;
  endproperty
  property p_mac_seen; s_mac_high |-> collisionSeen && carrierSeen; endproperty

  a_strap_held: assert property (p_strap_held) else $error("strap moved");
  a_ref_in: assert property (p_ref_in) else $error("ref input setup");
  a_ref_in_iso: assert property (p_ref_in_iso) else $error("ref isolate");
  a_ref_out: assert property (p_ref_out) else $error("ref output buffer");
  a_ref_drive: assert property (p_ref_drive) else $error("ref drive");
  a_ref_iso: assert property (p_ref_iso) else $error("ref driver on");
  a_ref_toggle: assert property (p_ref_toggle) else $error("ref stuck");
  a_phy_iso: assert property (p_phy_iso) else $error("col crs driven");
  a_phy_live: assert property (p_phy_live) else $error("col crs off");
  a_rmii_idle: assert property (p_rmii_idle) else $error("col crs used");
  a_mac_seen: assert property (p_mac_seen) else $error("col crs missed");
endmodule : port0_pin_control_asserts

// ---- bench/port0_ext_partner.sv ----
// external mac or phy at the port 0 collision and carrier pins
// assumes active-low enables; resolves each pin for the design's inputs
module port0_ext_partner (
  // design side of the pins
  input  wire logic colOut,
  input  wire logic colOutEn_n,
  input  wire logic crsOut,
  input  wire logic crsOutEn_n,
  // external device drive
  input  wire logic extOn,
  input  wire logic extCol,
  input  wire logic extCrs,
  // resolved pins
  output logic      colIn,
  output logic      crsIn
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins released by the design with extOn low settle at their pulls: collision up, carrier down
  assign colIn = !colOutEn_n ? colOut : (extOn ? extCol : 1'b1);
  assign crsIn = !crsOutEn_n ? crsOut : (extOn ? extCrs : 1'b0);
endmodule : port0_ext_partner

// ---- bench/port0_mii_rmii_pin_control_tb_top.sv ----
// top-level bench for port 0 pin control
// assumes checker and partner files are compiled before this one
module port0_mii_rmii_pin_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk = 1'b0;
  logic       linkClk  = 1'b0;
  logic       reset    = 1'b1;
  logic [2:0] strapPin = 3'h0;
  logic       dir = 1'b0, str16 = 1'b0, iso = 1'b0, colEv = 1'b0, crsEv = 1'b0;
  logic       extOn = 1'b0, extCol = 1'b0, extCrs = 1'b0;
  logic       colIn, crsIn, colOut, colOutEn_n, crsOut, crsOutEn_n, refClkOut;
  logic       refClkOutEn_n, bufEn, pdEn, drive16, modeValid, colSeen, crsSeen;
  logic [2:0] portModeStrap;
  logic       lastRef, resetOk;
  logic [3:0] pinView, linkView, expV;
  int         error_cnt   = 0;
  int         comparisons = 0;
  int         seed        = 32'h17622257;

  always #5 core_clk = ~core_clk;
  always #7.5 linkClk = ~linkClk;

  port0_pin_control u_port0_pin_control (.core_clk(core_clk), .reset(reset),
    .linkClk(linkClk), .modeStrapPin(strapPin), .clkDirOutput(dir),
    .clkStrength16(str16), .isolate(iso), .collisionEvent(colEv), .carrierEvent(crsEv),
    .colIn(colIn), .colOut(colOut), .colOutEn_n(colOutEn_n), .crsIn(crsIn),
    .crsOut(crsOut), .crsOutEn_n(crsOutEn_n), .refClkOut(refClkOut),
    .refClkOutEn_n(refClkOutEn_n), .refClkInBufEn(bufEn), .refClkPullDownEn(pdEn),
    .refClkDrive16mA(drive16), .portModeStrap(portModeStrap), .modeValid(modeValid),
    .collisionSeen(colSeen), .carrierSeen(crsSeen));
  port0_ext_partner u_port0_ext_partner (.colOut(colOut), .colOutEn_n(colOutEn_n),
    .crsOut(crsOut), .crsOutEn_n(crsOutEn_n), .extOn(extOn), .extCol(extCol),
    .extCrs(extCrs), .colIn(colIn), .crsIn(crsIn));

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // {0, driver enable_n, input buffer, pull-down}; phy and reserved modes leave it all off
  function automatic logic [3:0] expRef(input logic [2:0] m, input logic d, input logic i);
    if (m == 3'h0) return 4'h7;
    if (m == 3'h7 || m < 3'h4) return 4'h4;
    return d ? {1'b0, i, 2'b00} : {2'b01, !i, !i};
  endfunction : expRef

  task automatic doReset(input logic [2:0] s, output logic ok);
    @(negedge core_clk);
    reset    = 1'b1;
    strapPin = s;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    for (int i = 0; i < 10 && modeValid !== 1'b1; i++) @(negedge core_clk);
    ok = (modeValid === 1'b1);
    if (!ok) begin
      // a strap that never latches counts as a mismatch and ends the sweep
      error_cnt++;
    end else begin
      strapPin = ~s;
      repeat (3) @(negedge core_clk);
      check({1'b0, portModeStrap}, {1'b0, s});
    end
  endtask : doReset

  initial begin
    for (int m = 0; m < 8; m++) begin
      doReset(m[2:0], resetOk);
      if (!resetOk) break;
      extOn   = (m == 0);
      lastRef = refClkOut;
      repeat (40) begin
        @(negedge core_clk);
        expV = expRef(m[2:0], dir, iso);
        check({1'b0, refClkOutEn_n, bufEn, pdEn}, expV);
        check({3'h0, refClkOut}, {3'h0, !lastRef});
        if (m > 3 && m < 7 && dir && !iso) check({3'h0, drive16}, {3'h0, str16});
        lastRef = refClkOut;
        {dir, str16, iso} = 3'($random(seed));
      end
      for (int k = 0; k < 2; k++) begin
        iso = k[0];
        {colEv, crsEv} = 2'($random(seed));
        {extCol, extCrs} = k ? 2'b11 : 2'($random(seed));
        repeat (10) @(negedge core_clk);
        pinView  = {colOutEn_n, crsOutEn_n, colSeen, crsSeen};
        linkView = {colOutEn_n, crsOutEn_n, colIn, crsIn};
        // a released col pin floats up and a released crs pin down
        if (m == 0) check(pinView, {2'b11, extCol, extCrs});
        else if (m < 4) check(linkView, k ? 4'he : {2'b00, colEv, crsEv});
        else check(pinView, 4'hc);
      end
    end
    wrap_up();
  end
endmodule : port0_mii_rmii_pin_control_tb_top

bind port0_pin_control port0_pin_control_asserts u_port0_pin_control_asserts (
  .core_clk(core_clk), .reset(reset), .modeValid(modeValid),
  .portModeStrap(portModeStrap), .clkDirOutput(clkDirOutput), .clkStrength16(clkStrength16),
  .isolate(isolate), .colIn(colIn), .crsIn(crsIn), .colOutEn_n(colOutEn_n),
  .crsOutEn_n(crsOutEn_n), .refClkOut(refClkOut), .refClkOutEn_n(refClkOutEn_n),
  .refClkInBufEn(refClkInBufEn), .refClkPullDownEn(refClkPullDownEn),
  .refClkDrive16mA(refClkDrive16mA), .collisionSeen(collisionSeen),
  .carrierSeen(carrierSeen));
